// ===== logic/fob_overcurrent.sv
`timescale 1ns/1ps
`default_nettype none
module fob_overcurrent
    import fob_pkg::*;
#(
    parameter int PWM_W = 2
)(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             cycle_start_i,
    input  wire logic             above_limit_i,
    input  wire logic [PWM_W-1:0] pwm_i,
    output logic      [PWM_W-1:0] pwm_o,
    output logic      [THR_W-1:0] current_limit_threshold_o,
    output logic                  sense_negative_o,
    output logic                  overcurrent_trip_o
);

    if (PWM_W < 1 || PWM_W > 32) begin
        $error("PWM_W must be between 1 and 32");
    end

    fob_cfg_t         cfg_reg;
    fob_cfg_t         cfg_next;
    fob_stat_t        stat;
    logic             sticky_reg;
    logic             sticky_next;
    logic [7:0]       trip_cnt_reg;
    logic [7:0]       trip_cnt_next;
    logic             trip_d_reg;
    logic             trip_rise;
    logic [PWM_W-1:0] pwm_reg;
    logic [PWM_W-1:0] pwm_next;
    logic             ack_reg;
    logic             ack_next;
    logic [31:0]      rdat_reg;
    logic [31:0]      rdat_next;
    logic             bus_req;
    logic             bus_wr;
    logic [7:0]       rd_byte;

    fob_qualifier u_qualifier (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .cfg_i         (cfg_reg),
        .cycle_start_i (cycle_start_i),
        .above_limit_i (above_limit_i),
        .stat_o        (stat)
    );

    // Bus decode: one-cycle answer, ack dropped the cycle after
    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
    assign trip_rise = stat.tripped && !trip_d_reg;

    always_comb begin
        rd_byte = 8'h00;
        unique case (wb_adr_i)
            ADR_BLANK_DEBOUNCE: begin
                rd_byte = {{RSV_W{1'b0}}, cfg_reg.debounce, cfg_reg.blank};
            end
            ADR_THRESHOLD: begin
                rd_byte = {cfg_reg.threshold, 5'h00};
            end
            ADR_STATUS: begin
                rd_byte = {4'h0, sticky_reg, stat.watching, stat.blanking, stat.tripped};
            end
            ADR_TRIP_COUNT: begin
                rd_byte = trip_cnt_reg;
            end
            default: begin
                // Unmapped: acknowledged, reads zero, writes dropped
                rd_byte = 8'h00;
            end
        endcase
    end

    always_comb begin
        ack_next  = bus_req;
        rdat_next = rdat_reg;
        if (bus_req) begin
            rdat_next = {24'h00_0000, rd_byte};
        end
    end

    always_comb begin
        cfg_next = cfg_reg;
        if (bus_wr && wb_adr_i == ADR_BLANK_DEBOUNCE) begin
            // Reserved bits have no storage
            cfg_next.debounce = wb_dat_i[DEB_LSB +: DEB_W];
            cfg_next.blank    = wb_dat_i[BLANK_LSB +: BLANK_W];
        end
        if (bus_wr && wb_adr_i == ADR_THRESHOLD) begin
            cfg_next.threshold = wb_dat_i[THR_LSB +: THR_W];
        end
    end

    // Sticky trip flag: write one to clear, a new trip wins the clash
    always_comb begin
        sticky_next = sticky_reg;
        if (bus_wr && wb_adr_i == ADR_STATUS && wb_dat_i[ST_STICKY_BIT]) begin
            sticky_next = 1'b0;
        end
        if (trip_rise) begin
            sticky_next = 1'b1;
        end
    end

    // Saturating trip counter, any write clears it, a new trip in the same cycle wins and counts up below 8'hff, at 8'hff the write clears it
    always_comb begin
        trip_cnt_next = trip_cnt_reg;
        if (bus_wr && wb_adr_i == ADR_TRIP_COUNT) begin
            trip_cnt_next = TRIP_CNT_RST;
        end
        if (trip_rise && trip_cnt_reg != 8'hff) begin
            trip_cnt_next = 8'(trip_cnt_reg + 1'b1);
        end
    end

    // One register stage costs 20 ns but keeps the outputs glitch free
    always_comb begin
        pwm_next = pwm_i;
        if (stat.tripped) begin
            pwm_next = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg      <= '{threshold: THR_RST, debounce: DEB_RST, blank: BLANK_RST};
            sticky_reg   <= 1'b0;
            trip_cnt_reg <= TRIP_CNT_RST;
            trip_d_reg   <= 1'b0;
            pwm_reg      <= '0;
            ack_reg      <= 1'b0;
            rdat_reg     <= 32'h0000_0000;
        end else begin
            cfg_reg      <= cfg_next;
            sticky_reg   <= sticky_next;
            trip_cnt_reg <= trip_cnt_next;
            trip_d_reg   <= stat.tripped;
            pwm_reg      <= pwm_next;
            ack_reg      <= ack_next;
            rdat_reg     <= rdat_next;
        end
    end

    assign wb_ack_o                  = ack_reg;
    assign wb_dat_o                  = rdat_reg;
    assign pwm_o                     = pwm_reg;
    assign current_limit_threshold_o = cfg_reg.threshold;
    assign sense_negative_o          = cfg_reg.threshold[THR_POL_BIT];
    assign overcurrent_trip_o        = trip_d_reg;

endmodule
`default_nettype wire

// ===== logic/fob_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
module fob_qualifier
    import fob_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    input  wire fob_cfg_t cfg_i,
    input  wire logic     cycle_start_i,
    input  wire logic     above_limit_i,
    output fob_stat_t     stat_o
);

    fob_state_t       state_reg;
    fob_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] cnt_inc;

    if (fob_ns_to_cycles(BLANK_NS[7]) >= fob_ns_to_cycles(BLANK_NS[7] + CLK_PERIOD_NS)) begin
        $error("CNT_W too narrow for the longest blanking time");
    end

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cnt_inc    = CNT_W'(cnt_reg + 1'b1);
        if (cycle_start_i) begin
            // Turn-on edge opens blanking, also ends a tripped cycle
            state_next = FOB_BLANK;
            cnt_next   = '0;
        end else begin
            unique case (state_reg)
                FOB_BLANK: begin
                    // Comparator not looked at here
                    if (cnt_inc >= fob_blank_cycles(cfg_i.blank)) begin
                        state_next = FOB_WATCH;
                        cnt_next   = '0;
                    end else begin
                        cnt_next = cnt_inc;
                    end
                end
                FOB_WATCH: begin
                    if (!above_limit_i) begin
                        cnt_next = '0;
                    end else if (cnt_inc >= fob_deb_cycles(cfg_i.debounce)) begin
                        state_next = FOB_TRIP;
                        cnt_next   = '0;
                    end else begin
                        cnt_next = cnt_inc;
                    end
                end
                FOB_TRIP: begin
                    // Held until the next turn-on edge
                    state_next = FOB_TRIP;
                end
                default: begin
                    // Unused code falls back to watching
                    state_next = FOB_WATCH;
                    cnt_next   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= FOB_WATCH;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign stat_o.tripped  = (state_reg == FOB_TRIP);
    assign stat_o.blanking = (state_reg == FOB_BLANK);
    assign stat_o.watching = (state_reg == FOB_WATCH);

endmodule
`default_nettype wire

// ===== pkg/fob_pkg.sv
package fob_pkg;

    // Clock and counter sizing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CNT_W         = 6;

    // Register byte addresses
    localparam logic [7:0] ADR_BLANK_DEBOUNCE = 8'h00;
    localparam logic [7:0] ADR_THRESHOLD      = 8'h04;
    localparam logic [7:0] ADR_STATUS         = 8'h08;
    localparam logic [7:0] ADR_TRIP_COUNT     = 8'h0c;

    // Field positions inside the blank/debounce register
    localparam int BLANK_LSB = 0;
    localparam int BLANK_W   = 3;
    localparam int DEB_LSB   = 3;
    localparam int DEB_W     = 2;
    localparam int RSV_LSB   = 5;
    localparam int RSV_W     = 3;

    // Field positions inside the threshold register
    localparam int THR_LSB     = 5;
    localparam int THR_W       = 3;
    localparam int THR_POL_BIT = 2;

    // Status register bits
    localparam int ST_TRIP_BIT   = 0;
    localparam int ST_BLANK_BIT  = 1;
    localparam int ST_WATCH_BIT  = 2;
    localparam int ST_STICKY_BIT = 3;

    // Reset values
    localparam logic [DEB_W-1:0]   DEB_RST   = 2'h0;
    localparam logic [BLANK_W-1:0] BLANK_RST = 3'h0;
    localparam logic [THR_W-1:0]   THR_RST   = 3'h0;
    localparam logic [7:0]         TRIP_CNT_RST = 8'h00;

    // Timings in ns
    localparam int DEB_NS   [4] = '{40, 80, 120, 240};
    localparam int BLANK_NS [8] = '{40, 80, 120, 160, 200, 400, 600, 800};

    typedef struct packed {
        logic [THR_W-1:0]   threshold;
        logic [DEB_W-1:0]   debounce;
        logic [BLANK_W-1:0] blank;
    } fob_cfg_t;

    typedef struct packed {
        logic watching;
        logic blanking;
        logic tripped;
    } fob_stat_t;

    typedef enum logic [1:0] {
        FOB_WATCH,
        FOB_BLANK,
        FOB_TRIP
    } fob_state_t;

    // Least time: round up, never below one cycle
    function automatic logic [CNT_W-1:0] fob_ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    function automatic logic [CNT_W-1:0] fob_deb_cycles(input logic [DEB_W-1:0] code);
        return fob_ns_to_cycles(DEB_NS[code]);
    endfunction

    function automatic logic [CNT_W-1:0] fob_blank_cycles(input logic [BLANK_W-1:0] code);
        return fob_ns_to_cycles(BLANK_NS[code]);
    endfunction

endpackage

// ===== sim/fob_overcurrent_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fob_overcurrent_assertions
    import fob_pkg::*;
#(
    parameter int PWM_W = 2
)(
    input wire logic             clk_i,
    input wire logic             rst_n_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [7:0]       wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             cycle_start_i,
    input wire logic             above_limit_i,
    input wire logic [PWM_W-1:0] pwm_i,
    input wire logic [PWM_W-1:0] pwm_o,
    input wire logic [THR_W-1:0] current_limit_threshold_o,
    input wire logic             sense_negative_o,
    input wire logic             overcurrent_trip_o
);
    localparam logic [7:0] NB [8] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h14, 8'h1e, 8'h28};
    localparam logic [7:0] ND [4] = '{8'h02, 8'h04, 8'h06, 8'h0c};
    // Own mirror of the blank and debounce config and of the high run seen after blanking
    logic [2:0] blk_reg;
    logic [1:0] deb_reg;
    logic [7:0] since_reg;
    logic [7:0] run_reg;
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic cfg_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_BLANK_DEBOUNCE;
    wire logic watch = !cycle_start_i && since_reg >= NB[blk_reg];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blk_reg   <= BLANK_RST;
            deb_reg   <= DEB_RST;
            since_reg <= 8'hff;
            run_reg   <= 8'h00;
        end else begin
            if (cfg_wr) begin
                blk_reg <= wb_dat_i[2:0];
                deb_reg <= wb_dat_i[4:3];
            end
            since_reg <= cycle_start_i ? 8'h00 : since_reg + 8'(since_reg != 8'hff);
            run_reg   <= (watch && above_limit_i) ? run_reg + 8'(run_reg != 8'hff) : 8'h00;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_thr_write;
        take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_THRESHOLD;
    endsequence
    sequence s_qualified;
        run_reg == ND[deb_reg];
    endsequence
    chk_ack_one_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bad ack");
    chk_cfg_readback: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == ADR_BLANK_DEBOUNCE |-> wb_dat_o == 32'({deb_reg, blk_reg}))
        else $error("bad cfg read");
    chk_thr_setting: assert property (s_thr_write |=>
        current_limit_threshold_o == wb_dat_i[7:5] && sense_negative_o == wb_dat_i[7])
        else $error("bad threshold");
    chk_trip_timing: assert property (s_qualified |=> overcurrent_trip_o)
        else $error("late trip");
    chk_debounce_min: assert property (
        $rose(overcurrent_trip_o) |-> $past(run_reg) >= ND[deb_reg])
        else $error("early trip");
    chk_trip_gates_pwm: assert property (overcurrent_trip_o |-> pwm_o == '0)
        else $error("pwm not gated");
    chk_trip_ends: assert property (cycle_start_i |-> ##2 (!overcurrent_trip_o) [*3])
        else $error("trip held");
    chk_pwm_passes: assert property (
        !overcurrent_trip_o && $past(rst_n_i) |-> pwm_o == $past(pwm_i))
        else $error("pwm not passed");
endmodule
bind fob_overcurrent fob_overcurrent_assertions #(.PWM_W(PWM_W)) fob_overcurrent_assertions_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cycle_start_i(cycle_start_i),
    .above_limit_i(above_limit_i), .pwm_i(pwm_i), .pwm_o(pwm_o),
    .current_limit_threshold_o(current_limit_threshold_o),
    .sense_negative_o(sense_negative_o), .overcurrent_trip_o(overcurrent_trip_o));
`default_nettype wire

// ===== sim/fob_pwm_side.sv
`timescale 1ns/1ps
`default_nettype none
module fob_pwm_side #(
    parameter int PWM_W = 2
)(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        fire_i,
    input  wire logic        over_i,
    output logic             cycle_start_o,
    output logic             above_limit_o,
    output logic [PWM_W-1:0] pwm_o
);
    // PWM output stays on once started, so any gap seen is the gating
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cycle_start_o <= 1'b0;
            above_limit_o <= 1'b0;
            pwm_o         <= '0;
        end else begin
            cycle_start_o <= fire_i;
            above_limit_o <= over_i;
            pwm_o         <= fire_i ? '1 : pwm_o;
        end
    end
endmodule
`default_nettype wire

// ===== sim/test_fob_overcurrent.sv
`timescale 1ns/1ps
`default_nettype none
module test_fob_overcurrent
    import fob_pkg::*;
;
    logic        clk_i;
    logic        rst_n_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        fire = 1'b0;
    logic        over = 1'b0;
    logic        ack, cs, above, neg, trip;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic [1:0]  pwm_raw, pwm_gated;
    logic [2:0]  thr;
    int          failures = 0;
    int          n_tests = 0;

    fob_overcurrent #(.PWM_W(2)) fob_overcurrent_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cycle_start_i(cs),
        .above_limit_i(above), .pwm_i(pwm_raw), .pwm_o(pwm_gated),
        .current_limit_threshold_o(thr), .sense_negative_o(neg), .overcurrent_trip_o(trip));
    fob_pwm_side #(.PWM_W(2)) fob_pwm_side_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
        .over_i(over), .cycle_start_o(cs), .above_limit_o(above), .pwm_o(pwm_raw));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Comparator held high from the turn-on edge, so only blanking plus debounce delays the trip
    // Two extra edges: turn-on sample and registered trip output
    // A one-cycle dropout g edges after the turn-on sample restarts the debounce
    task automatic run(input int b, input int d, input int g);
        int k;
        int e;
        k = 0;
        e = (BLANK_NS[b] + DEB_NS[d]) / CLK_PERIOD_NS + 2;
        if (g > 0) begin
            e = DEB_NS[d] / CLK_PERIOD_NS + g + 4;
        end
        wb(1'b1, ADR_BLANK_DEBOUNCE, 32'(d * 8 + b));
        fire <= 1'b1;
        over <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        do @(posedge clk_i); while (cs !== 1'b1);
        while (trip !== 1'b1 && k < 100) begin
            if (g > 0 && k == g) begin
                over <= 1'b0;
            end
            if (g > 0 && k == g + 1) begin
                over <= 1'b1;
            end
            @(posedge clk_i);
            k++;
        end
        chk(32'(k), 32'(e));
        chk(32'(pwm_gated), 32'h0000_0000);
        over <= 1'b0;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(32'({trip, pwm_gated}), 32'h0000_0003);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        wb(1'b0, ADR_BLANK_DEBOUNCE, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b1, ADR_BLANK_DEBOUNCE, 32'h0000_00ff);
        wb(1'b0, ADR_BLANK_DEBOUNCE, 32'h0000_0000);
        chk(q, 32'h0000_001f);
        wb(1'b1, ADR_THRESHOLD, 32'h0000_00a0);
        chk(32'({thr, neg}), 32'h0000_000b);
        wb(1'b0, 8'h10, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        for (int b = 0; b < 8; b++) run(b, 0, 0);
        for (int d = 1; d < 4; d++) run(0, d, 0);
        run(0, 1, 4);
        wb(1'b0, ADR_TRIP_COUNT, 32'h0000_0000);
        chk(q, 32'h0000_000c);
        wb(1'b0, ADR_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_000c);
        wb(1'b1, ADR_STATUS, 32'h0000_0008);
        wb(1'b0, ADR_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0004);
        wb(1'b1, ADR_TRIP_COUNT, 32'h0000_0000);
        wb(1'b0, ADR_TRIP_COUNT, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        report_and_stop();
    end

    initial begin
        #(CLK_PERIOD_NS * 20000);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
